// ---- core/cmcg_pkg.sv ----
// Purpose: shared constants and types for the cpu module clock gating block
// Assumes: one 125 MHz core clock, plain register port with 32-bit data
// Notes:   offsets are byte addresses of 32-bit words
package cmcg_pkg;

  // register port geometry
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 32;

  // register offsets
  localparam logic [7:0]  OFS_MOD_CTRL      = 8'h00;  // cpu_module_control
  localparam logic [7:0]  OFS_XFER_CMD      = 8'h04;  // domain_transition_command
  localparam logic [7:0]  OFS_XFER_STAT     = 8'h08;  // domain_transition_status
  localparam logic [7:0]  OFS_MOD_STAT      = 8'h0c;  // cpu_module_status
  localparam logic [7:0]  OFS_PLL_CTRL      = 8'h10;
  localparam logic [7:0]  OFS_PLL_STAT      = 8'h14;

  // field positions
  localparam int          CTRL_FORCE_BIT    = 31;
  localparam int          NEXT_W            = 3;
  localparam int          CMD_GO_BIT        = 0;      // always_on_domain go
  localparam int          STAT_BUSY_BIT     = 0;      // domain_busy_bit
  localparam int          MSTAT_LRST_BIT    = 8;
  localparam int          MSTAT_STATE_W     = 6;
  localparam int          PLL_NUM           = 2;      // 0 main, 1 memory
  localparam int          PLL_FIELD_W       = 4;      // bits per pll in pll control
  localparam int          PLLF_BYPASS       = 0;
  localparam int          PLLF_PD           = 1;
  localparam int          PLLF_EXT_SRC      = 2;

  // reset values
  localparam logic [31:0] MOD_CTRL_RST      = 32'h0000_0000;
  localparam logic [7:0]  PLL_CTRL_RST      = 8'h00;

  // module states as seen in the next and state fields
  typedef enum logic [2:0] {
    MS_RESET_HELD_CLOCK_OFF = 3'h0,
    MS_RESET_HELD_CLOCK_ON  = 3'h1,
    MS_DISABLE              = 3'h2,
    MS_ENABLE               = 3'h3
  } cmcg_mstate_t;

  // state field base while a transition runs, keeps it inside 4h..3Fh
  localparam logic [5:0]  TRANS_CODE_BASE   = 6'h08;

  // transition sequencer, gray coded along the stop path
  typedef enum logic [2:0] {
    SQ_IDLE      = 3'b000,
    SQ_STOP_REQ  = 3'b001,
    SQ_BUS_DRAIN = 3'b011,
    SQ_APPLY     = 3'b010,
    SQ_WAKE_WAIT = 3'b110
  } cmcg_seq_t;

  // timing
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          PLL_LOCK_TIME_NS  = 100000;
  localparam int          PLL_LOCK_CYCLES   =
    (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cmcg_bus_req_t;

  // clock selection controls for one pll controller
  typedef struct packed {
    logic pd;          // pll powered down
    logic bypass;      // dividers fed from bypass clock
    logic ext_src;     // bypass clock from second_pll_third_output
  } cmcg_pll_out_t;

endpackage : cmcg_pkg

// ---- core/cmcg_ctrl.sv ----
// Purpose: cpu local_module_controller with clock stop handshake and pll clock selection
// Assumes: core side inputs come from logic on core_clk, no synchronisers needed
// Notes:   clock gating is expressed as enables and mux selects for the clock cells
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps

module cmcg_ctrl
  #(
    parameter int LOCK_CYCLES = cmcg_pkg::PLL_LOCK_CYCLES
  )
  (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // register port
    input  wire cmcg_pkg::cmcg_bus_req_t bus_req,
    output logic [cmcg_pkg::DATA_W-1:0]  bus_rdata,
    // processor core side
    input  wire logic                    cpu_bus_busy,
    input  wire logic                    cpu_wfi,
    input  wire logic                    cpu_irq,
    input  wire logic                    cpu_fiq,
    output logic                         cpu_clock_stop_request,
    output logic                         cpu_clk_en,
    output logic                         cpu_rst_n,
    // pll clock selection
    output cmcg_pkg::cmcg_pll_out_t      main_pll_sel,
    output cmcg_pkg::cmcg_pll_out_t      mem_pll_sel
  );

  import cmcg_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

  // how a transition runs:
  // a go write is taken only while the sequencer is idle, with a legal next
  // code that differs from the current state; the target is latched then,
  // so software may rewrite the next field at once without harm.
  // a stop (clock-on state to clock-off state) first raises the stop
  // request and waits for the core to enter wait sleep; the core's routine
  // is trusted to drain its own masters, but the bus drain step still
  // checks for a live access, because gating mid-access can lose it.
  // an enable out of disable while the core sleeps waits in the wake wait
  // step with the clock still gated; the clock opens only when the wake
  // interrupt arrives, and the transition completes once that interrupt is seen.
  // force skips both handshakes but still waits for the bus drain; a
  // forced stop of a core that is mid-routine is the user's own risk.
  // limitation: a go that arrives while busy is silently dropped, there is
  // no error flag, so software must poll busy before every go.

  // true for the states in which the cpu clock runs
  function automatic logic clk_on_state(input logic [NEXT_W-1:0] st);
    clk_on_state = (st == MS_RESET_HELD_CLOCK_ON) || (st == MS_ENABLE);
  endfunction : clk_on_state

  // true for the states in which the cpu reset is held
  function automatic logic rst_held_state(input logic [NEXT_W-1:0] st);
    rst_held_state = (st == MS_RESET_HELD_CLOCK_OFF) || (st == MS_RESET_HELD_CLOCK_ON);
  endfunction : rst_held_state

  logic [31:0]                  mod_ctrl_reg;
  logic [PLL_NUM*PLL_FIELD_W-1:0] pll_ctrl_reg;
  cmcg_seq_t                    seq_reg;
  cmcg_seq_t                    seq_next;
  logic [NEXT_W-1:0]            cur_reg;
  logic [NEXT_W-1:0]            target_reg;
  logic                         sleeping_reg;
  logic                         stop_req_reg;
  logic                         clk_en_reg;
  logic                         rst_n_reg;
  logic [DATA_W-1:0]            rdata_reg;
  logic [PLL_NUM-1:0]           locked;
  cmcg_pll_out_t                pll_sel_reg [PLL_NUM];

  logic                         go_pulse;
  logic [NEXT_W-1:0]            next_field;
  logic                         force_on;
  logic                         wake;
  logic                         busy;
  logic [MSTAT_STATE_W-1:0]     state_code;

  // decoded register strobes and fields
  assign go_pulse   = bus_req.wr && (bus_req.addr == OFS_XFER_CMD) && bus_req.wdata[CMD_GO_BIT];
  assign next_field = mod_ctrl_reg[NEXT_W-1:0];
  assign force_on   = mod_ctrl_reg[CTRL_FORCE_BIT];
  assign wake       = cpu_irq || cpu_fiq;
  assign busy       = (seq_reg != SQ_IDLE);

  // state field shows the settled state or a transition code
  assign state_code = busy ? (TRANS_CODE_BASE | {3'b000, seq_reg})
                           : {3'b000, cur_reg};

  // module control register, only next and force bits are kept
  always_ff @(posedge core_clk)
  begin
    if (rst)
      mod_ctrl_reg <= MOD_CTRL_RST;
    else if (bus_req.wr && (bus_req.addr == OFS_MOD_CTRL))
    begin
      mod_ctrl_reg                 <= '0;
      mod_ctrl_reg[CTRL_FORCE_BIT] <= bus_req.wdata[CTRL_FORCE_BIT];
      mod_ctrl_reg[NEXT_W-1:0]     <= bus_req.wdata[NEXT_W-1:0];
    end
  end

  // pll control register
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pll_ctrl_reg <= PLL_CTRL_RST;
    else if (bus_req.wr && (bus_req.addr == OFS_PLL_CTRL))
      pll_ctrl_reg <= bus_req.wdata[PLL_NUM*PLL_FIELD_W-1:0];
  end

  // next step of the transition sequencer
  always_comb
  begin
    seq_next = seq_reg;
    case (seq_reg)
      SQ_IDLE:
      begin
        // a go with nothing to change, or a code above enable, is dropped
        if (go_pulse && (next_field <= MS_ENABLE) && (next_field != cur_reg))
        begin
          if (force_on)
            seq_next = SQ_BUS_DRAIN;
          else if (clk_on_state(cur_reg) && !clk_on_state(next_field))
            seq_next = SQ_STOP_REQ;
          else if ((cur_reg == MS_DISABLE) && clk_on_state(next_field) && sleeping_reg)
            seq_next = SQ_WAKE_WAIT;
          else
            seq_next = SQ_BUS_DRAIN;
        end
      end
      SQ_STOP_REQ:
      begin
        if (cpu_wfi)
          seq_next = SQ_BUS_DRAIN;
      end
      SQ_BUS_DRAIN:
      begin
        if (!cpu_bus_busy)
          seq_next = SQ_APPLY;
      end
      SQ_WAKE_WAIT:
      begin
        if (wake)
          seq_next = SQ_APPLY;
      end
      SQ_APPLY:
        seq_next = SQ_IDLE;
      default:
        seq_next = SQ_IDLE;
    endcase
  end

  // sequencer state and the latched target
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      seq_reg    <= SQ_IDLE;
      target_reg <= MS_RESET_HELD_CLOCK_OFF;
    end
    else
    begin
      seq_reg <= seq_next;
      if ((seq_reg == SQ_IDLE) && (seq_next != SQ_IDLE))
        target_reg <= next_field;  // later writes to next do not disturb a running transition
    end
  end

  // current module state, changes only at the apply step
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cur_reg <= MS_RESET_HELD_CLOCK_OFF;
    else if (seq_reg == SQ_APPLY)
      cur_reg <= target_reg;
  end

  // stop request line to the cpu interrupt controller, held until sleep
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stop_req_reg <= 1'b0;
    else
      stop_req_reg <= (seq_next == SQ_STOP_REQ);
  end

  // wait sleep tracking; entry wins over a wake in the same cycle,
  // a level interrupt still held clears it one cycle later
  always_ff @(posedge core_clk)
  begin
    if (rst)
      sleeping_reg <= 1'b0;
    else if (cpu_wfi)
      sleeping_reg <= 1'b1;
    else if (wake)
      sleeping_reg <= 1'b0;
  end

  // cpu clock enable: off in clock-off states (save the wake wait step once a wake arrives) and while asleep, and
  // only a gate, so flops inside keep their values across the stop
  always_ff @(posedge core_clk)
  begin
    if (rst)
      clk_en_reg <= 1'b0;
    else
      clk_en_reg <= (clk_on_state(cur_reg) || (seq_reg == SQ_WAKE_WAIT))
                    && !(sleeping_reg && !wake);
  end

  // cpu reset: released in disable so that state survives the stop
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rst_n_reg <= 1'b0;
    else
      rst_n_reg <= !rst_held_state(cur_reg);
  end

  // per pll lock timer and clock selection
  // the timer stands in for the analog lock detector: it reloads while the
  // pll is powered down and counts down once power returns. bypass alone
  // never touches it, so leaving bypass is immediate while lock is held.
  // trade-off: a fixed count is pessimistic against a real detector, but
  // it cannot report lock early, which would feed the dividers a bad clock.
  // the memory pll keeps its source bit forced low, whatever software
  // writes, since its bypass clock has no second source to choose.
  genvar g;
  generate
    for (g = 0; g < PLL_NUM; g = g + 1)
    begin : g_pll
      logic [LOCK_W-1:0] lock_cnt_reg;
      logic              pd_bit;
      logic              bypass_bit;
      logic              ext_bit;

      assign pd_bit     = pll_ctrl_reg[g*PLL_FIELD_W + PLLF_PD];
      assign bypass_bit = pll_ctrl_reg[g*PLL_FIELD_W + PLLF_BYPASS];
      // memory pll has no source choice
      assign ext_bit    = (g == 0) ? pll_ctrl_reg[g*PLL_FIELD_W + PLLF_EXT_SRC] : 1'b0;

      // lock timer restarts only on power down, bypass leaves it alone
      always_ff @(posedge core_clk)
      begin
        if (rst)
          lock_cnt_reg <= LOCK_W'(LOCK_CYCLES);
        else if (pd_bit)
          lock_cnt_reg <= LOCK_W'(LOCK_CYCLES);
        else if (lock_cnt_reg != '0)
          lock_cnt_reg <= lock_cnt_reg - 1'b1;
      end

      assign locked[g] = (lock_cnt_reg == '0);

      // bypass is forced until lock, so an early switch back is harmless
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          pll_sel_reg[g].pd      <= 1'b0;
          pll_sel_reg[g].bypass  <= 1'b1;
          pll_sel_reg[g].ext_src <= 1'b0;
        end
        else
        begin
          pll_sel_reg[g].pd      <= pd_bit;
          pll_sel_reg[g].bypass  <= bypass_bit || pd_bit || !locked[g];
          pll_sel_reg[g].ext_src <= ext_bit;
        end
      end
    end
  endgenerate

  // read data, valid only in the cycle after the read strobe
  // the word is zeroed in every other cycle, so a master that samples late
  // sees zero rather than stale status; the module status word carries the
  // core reset level beside the state field, so software can see that a
  // disable kept the reset released.
  // the command word is write only: reading it returns zero, so a go is
  // never echoed back and mistaken for a pending transition.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (bus_req.rd)
    begin
      rdata_reg <= '0;
      case (bus_req.addr)
        OFS_MOD_CTRL:
          rdata_reg <= mod_ctrl_reg;
        OFS_XFER_STAT:
          rdata_reg[STAT_BUSY_BIT] <= busy;
        OFS_MOD_STAT:
        begin
          rdata_reg[MSTAT_STATE_W-1:0] <= state_code;
          rdata_reg[MSTAT_LRST_BIT]    <= rst_n_reg;
        end
        OFS_PLL_CTRL:
          rdata_reg[PLL_NUM*PLL_FIELD_W-1:0] <= pll_ctrl_reg;
        OFS_PLL_STAT:
          rdata_reg[PLL_NUM-1:0] <= locked;
        default:
          rdata_reg <= '0;  // command register and unmapped words read zero
      endcase
    end
    else
      rdata_reg <= '0;
  end

  // outputs straight from flops
  assign bus_rdata              = rdata_reg;
  assign cpu_clock_stop_request = stop_req_reg;
  assign cpu_clk_en             = clk_en_reg;
  assign cpu_rst_n              = rst_n_reg;
  assign main_pll_sel           = pll_sel_reg[0];
  assign mem_pll_sel            = pll_sel_reg[1];

endmodule : cmcg_ctrl

// ---- verification/cmcg_cpu_model.sv ----
// Purpose: behavioural processor core facing the clock gating controller
// Assumes: service routine length and wake sources come from the bench
// Notes:   the routine counts only while the core clock runs
`timescale 1ns/100ps
module cmcg_cpu_model
  (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // from the controller
    input  wire logic       cpu_clock_stop_request,
    input  wire logic       cpu_clk_en,
    // bench commands
    input  wire logic [3:0] isr_len,
    input  wire logic       hold_bus,
    input  wire logic       wake_irq,
    input  wire logic       wake_fiq,
    // core side
    output logic            cpu_wfi,
    output logic            cpu_bus_busy,
    output logic            cpu_irq,
    output logic            cpu_fiq
  );
  logic [3:0] isr_cnt_reg;

  // stop request service routine, entered in supervisor mode with wake armed
  always_ff @(posedge core_clk)
  begin
    if (rst || !cpu_clock_stop_request)
      isr_cnt_reg <= 4'h0;
    else if (cpu_clk_en && !cpu_wfi)
      isr_cnt_reg <= isr_cnt_reg + 4'h1;
  end

  // masters drain first, sleep only once they are done
  assign cpu_bus_busy = hold_bus || (cpu_clock_stop_request && isr_cnt_reg < isr_len);
  assign cpu_wfi      = cpu_clock_stop_request && isr_cnt_reg == isr_len;

  // chip signal wake lines, kept enabled through the sleep
  always_ff @(posedge core_clk)
  begin
    cpu_irq <= !rst && wake_irq;
    cpu_fiq <= !rst && wake_fiq;
  end
endmodule : cmcg_cpu_model

// ---- verification/cmcg_ctrl_chk.sv ----
// Purpose: port assertions for the cpu module clock gating controller
// Assumes: one clock domain, synchronous active high reset
// Notes:   bus drain timing follows the go, drain, apply, update chain
`timescale 1ns/100ps
module cmcg_chk
  import cmcg_pkg::*;
  #(
    parameter int LOCK_CYCLES = 8
  )
  (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // register port
    input wire cmcg_bus_req_t         bus_req,
    input wire logic [DATA_W-1:0]     bus_rdata,
    // processor core side
    input wire logic                  cpu_bus_busy,
    input wire logic                  cpu_wfi,
    input wire logic                  cpu_irq,
    input wire logic                  cpu_fiq,
    input wire logic                  cpu_clock_stop_request,
    input wire logic                  cpu_clk_en,
    input wire logic                  cpu_rst_n,
    // pll selection
    input wire cmcg_pll_out_t         main_pll_sel,
    input wire cmcg_pll_out_t         mem_pll_sel
  );
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // go write decode, request may only follow one
  logic go_wr;
  assign go_wr = bus_req.wr && bus_req.addr == OFS_XFER_CMD && bus_req.wdata[CMD_GO_BIT];

  stop_rise_a: assert property ($rose(cpu_clock_stop_request) |-> $past(go_wr))
    else $error("stop request without go");
  stop_hold_a: assert property (cpu_clock_stop_request && !cpu_wfi |=> cpu_clock_stop_request)
    else $error("stop request dropped early");
  stop_drop_a: assert property (cpu_clock_stop_request && cpu_wfi |=> !cpu_clock_stop_request)
    else $error("stop request kept after sleep");
  sleep_gate_a: assert property (cpu_wfi && !(cpu_irq || cpu_fiq) ##1 !(cpu_irq || cpu_fiq)
    |=> !cpu_clk_en)
    else $error("clock runs while asleep");
  drain_first_a: assert property ($fell(cpu_rst_n) |-> !$past(cpu_bus_busy, 3))
    else $error("module changed during bus access");
  reset_state_a: assert property ($fell(rst) |-> !cpu_clk_en && !cpu_rst_n
    && !cpu_clock_stop_request && main_pll_sel == 3'b010)
    else $error("wrong state after reset");
  mem_src_a: assert property (!mem_pll_sel.ext_src)
    else $error("memory pll bypass not oscillator");
  relock_wait_a: assert property ($fell(main_pll_sel.pd) |-> main_pll_sel.bypass [*4])
    else $error("pll used before relock");

  // main scenarios
  cover property (go_wr ##1 cpu_clock_stop_request);
  cover property ($fell(cpu_rst_n));
  cover property ($rose(cpu_clk_en) && cpu_rst_n);
endmodule : cmcg_chk

bind cmcg_ctrl cmcg_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .cpu_bus_busy(cpu_bus_busy), .cpu_wfi(cpu_wfi), .cpu_irq(cpu_irq), .cpu_fiq(cpu_fiq),
  .cpu_clock_stop_request(cpu_clock_stop_request), .cpu_clk_en(cpu_clk_en),
  .cpu_rst_n(cpu_rst_n), .main_pll_sel(main_pll_sel), .mem_pll_sel(mem_pll_sel));

// ---- verification/tb_cpu_module_clock_gating.sv ----
// Purpose: self-checking bench for the cpu module clock gating controller
// Assumes: lock count shortened to 8 cycles
// Notes:   random service routine lengths and wake sources, fixed seed
`timescale 1ns/100ps
module tb_cpu_module_clock_gating;
  import cmcg_pkg::*;
  localparam int LOCK = 8;
  logic          core_clk, rst, cpu_bus_busy, cpu_wfi, cpu_irq, cpu_fiq;
  logic          cpu_clock_stop_request, cpu_clk_en, cpu_rst_n;
  logic          hold_bus, wake_irq, wake_fiq;
  logic [3:0]    isr_len;
  logic [31:0]   bus_rdata, rd_val;
  cmcg_bus_req_t bus_req;
  cmcg_pll_out_t main_pll_sel, mem_pll_sel;
  integer        seed, error_cnt, n_checks, cyc;

  cmcg_ctrl #(.LOCK_CYCLES(LOCK)) DUT (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .cpu_bus_busy(cpu_bus_busy), .cpu_wfi(cpu_wfi), .cpu_irq(cpu_irq),
    .cpu_fiq(cpu_fiq), .cpu_clock_stop_request(cpu_clock_stop_request),
    .cpu_clk_en(cpu_clk_en), .cpu_rst_n(cpu_rst_n), .main_pll_sel(main_pll_sel),
    .mem_pll_sel(mem_pll_sel));
  cmcg_cpu_model u_cpu (.core_clk(core_clk), .rst(rst),
    .cpu_clock_stop_request(cpu_clock_stop_request), .cpu_clk_en(cpu_clk_en),
    .isr_len(isr_len), .hold_bus(hold_bus), .wake_irq(wake_irq), .wake_fiq(wake_fiq),
    .cpu_wfi(cpu_wfi), .cpu_bus_busy(cpu_bus_busy), .cpu_irq(cpu_irq), .cpu_fiq(cpu_fiq));

  // 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // hang guard, whole run needs a few hundred cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // expected status word: reset released only in disable and enable
  function automatic logic [31:0] exp_stat(input logic [2:0] s);
    return {23'h0, s[1], 2'b00, 3'h0, s};
  endfunction : exp_stat

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask : rd

  task automatic trans(input logic [31:0] ctrl);
    wr(OFS_MOD_CTRL, ctrl);
    wr(OFS_XFER_CMD, 32'h1);
    #1;
  endtask : trans

  task automatic wait_idle;
    rd(OFS_XFER_STAT);
    for (int i = 0; i < 200 && rd_val[0] !== 1'b0; i++)
      rd(OFS_XFER_STAT);
  endtask : wait_idle

  initial
  begin
    seed = 96063;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    rst = 1'b1;
    bus_req = '0;
    {isr_len, hold_bus, wake_irq, wake_fiq} = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (LOCK + 2) @(posedge core_clk);
    rd(OFS_MOD_STAT);
    check(rd_val, exp_stat(3'h0));
    rd(OFS_PLL_STAT);
    check(rd_val, 32'h3);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c);
    check(rd_val, 32'h0);
    trans(32'h3);
    wait_idle();
    rd(OFS_MOD_STAT);
    check(rd_val, exp_stat(3'h3));
    check(32'(cpu_clk_en), 32'h1);
    // stop and restart the core with random routine lengths and wake lines
    repeat (3)
    begin
      @(posedge core_clk);
      isr_len <= 4'($random(seed));
      trans(32'h2);
      check(32'(cpu_clock_stop_request), 32'h1);
      rd(OFS_XFER_STAT);
      check(rd_val, 32'h1);
      wait_idle();
      rd(OFS_MOD_STAT);
      check(rd_val, exp_stat(3'h2));
      check(32'({cpu_clk_en, cpu_rst_n}), 32'h1);
      trans(32'h3);
      repeat (4 + ($random(seed) & 7)) @(posedge core_clk);
      rd(OFS_XFER_STAT);
      check(rd_val, 32'h1);
      @(posedge core_clk);
      {wake_fiq, wake_irq} <= ($random(seed) & 1) ? 2'b10 : 2'b01;
      wait_idle();
      @(posedge core_clk);
      {wake_fiq, wake_irq} <= 2'b00;
      rd(OFS_MOD_STAT);
      check(rd_val, exp_stat(3'h3));
      check(32'(cpu_clk_en), 32'h1);
    end
    // refused go: code out of range, then same state again
    trans(32'h5);
    rd(OFS_XFER_STAT);
    check(rd_val, 32'h0);
    trans(32'h3);
    rd(OFS_XFER_STAT);
    check(rd_val, 32'h0);
    // forced stop waits for the bus, no handshake
    @(posedge core_clk);
    hold_bus <= 1'b1;
    trans(32'h8000_0000);
    check(32'(cpu_clock_stop_request), 32'h0);
    repeat (6) @(posedge core_clk);
    rd(OFS_XFER_STAT);
    check(rd_val, 32'h1);
    @(posedge core_clk);
    hold_bus <= 1'b0;
    wait_idle();
    rd(OFS_MOD_STAT);
    check(rd_val, exp_stat(3'h0));
    for (int i = 0; i < 2; i++)
    begin
      trans(32'h8000_0000 | (i ? 32'h3 : 32'h1));
      wait_idle();
      rd(OFS_MOD_STAT);
      check(rd_val, exp_stat(i ? 3'h3 : 3'h1));
    end
    // pll bypass, power down and relock
    // selection flops follow the control register one edge later
    wr(OFS_PLL_CTRL, 32'h3);
    @(posedge core_clk);
    @(negedge core_clk);
    check(32'(main_pll_sel), 32'h6);
    wr(OFS_PLL_CTRL, 32'h4);
    @(posedge core_clk);
    @(negedge core_clk);
    check(32'(main_pll_sel), 32'h3);
    repeat (LOCK + 4) @(posedge core_clk);
    @(negedge core_clk);
    check(32'(main_pll_sel), 32'h1);
    wr(OFS_PLL_CTRL, 32'h51);
    @(posedge core_clk);
    @(negedge core_clk);
    check(32'(mem_pll_sel), 32'h2);
    rd(OFS_PLL_STAT);
    check(rd_val, 32'h3);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_MOD_STAT);
    check(rd_val, exp_stat(3'h0));
    stop_test();
  end
endmodule : tb_cpu_module_clock_gating
